// >>> inc/exec_pkg.sv
// Purpose: shared constants and types for the instruction subset executor
// Assumes: register byte offsets sit in haddr[7:0], one word each
// Notes:   opcode and state codes are fixed here only
package exec_pkg;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned PC_W    = 15;
  localparam int unsigned LATCH_W = 7;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned IDX_W   = 6;
  localparam int unsigned CNT_W   = 16;
  localparam int unsigned PRESC_W = 8;
  // register byte offsets
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_STAT  = 8'h04;
  localparam logic [7:0] OFF_ACCUM = 8'h08;
  localparam logic [7:0] OFF_PC    = 8'h0C;
  localparam logic [7:0] OFF_LATCH = 8'h10;
  localparam logic [7:0] OFF_STACK = 8'h14;
  localparam logic [7:0] OFF_WDOG  = 8'h18;
  localparam logic [7:0] OFF_CTRL  = 8'h1C;
  localparam logic [7:0] OFF_FPTR  = 8'h20;
  localparam logic [7:0] OFF_FDATA = 8'h24;
  localparam logic [7:0] OFF_COUNT = 8'h28;
  // field positions
  localparam int unsigned INSTR_OP_LSB = 0;
  localparam int unsigned INSTR_F_LSB  = 4;
  localparam int unsigned INSTR_D_BIT  = 12;
  localparam int unsigned STAT_BUSY    = 0;
  localparam int unsigned STAT_Z       = 1;
  localparam int unsigned STAT_TO      = 2;
  localparam int unsigned STAT_PD      = 3;
  localparam int unsigned CTRL_WDT_EN  = 0;
  localparam int unsigned WDOG_PRE_LSB = 8;
  // reset and clear values
  localparam logic [7:0]  ACCUM_RST = 8'h00;
  localparam logic [14:0] PC_RST    = 15'h0000;
  localparam logic [7:0]  WDOG_CLR  = 8'h00;
  localparam logic [7:0]  FILE_CLR  = 8'h00;
  localparam logic        FLAG_RST  = 1'b1;
  typedef enum logic [2:0] {
    OP_NOP = 3'h0, OP_WDOG_CLR = 3'h1, OP_CALL = 3'h2, OP_COMPLEMENT_FILE_OP = 3'h3,
    OP_CLEAR_FILE_OP = 3'h4, OP_DECREMENT_FILE_OP = 3'h5, OP_CLEAR_ACCUM_OP = 3'h6, OP_DECSZ = 3'h7
  } op_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_EXEC = 3'b010, ST_SECOND = 3'b100
  } state_e;
endpackage : exec_pkg

// >>> inc/reg_access_if.sv
// Purpose: register access path between bus port and core
// Assumes: one clock, word index addressing
// Notes:   rdata answers rd_idx in the same cycle
`timescale 1ns/1ns
`default_nettype none
interface reg_access_if;
  logic [5:0]  rd_idx;
  logic        rd_ok;
  logic        wr_en;
  logic [5:0]  wr_idx;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport port (output rd_idx, rd_ok, wr_en, wr_idx, wdata, input rdata);
  modport core (input rd_idx, rd_ok, wr_en, wr_idx, wdata, output rdata);
endinterface : reg_access_if
`default_nettype wire

// >>> core/ahb_reg_port.sv
// Purpose: AHB-Lite slave front end, zero wait states
// Assumes: single word transfers, haddr[7:2] decoded, haddr[31:8] must be zero
// Notes:   read data is captured at the address phase edge
`timescale 1ns/1ns
`default_nettype none
module ahb_reg_port (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  reg_access_if.port       ra
);
  logic       addr_ok;
  logic       in_range;
  logic       wr_pend_q;
  logic [5:0] wr_idx_q;

  // hsize is not checked: only whole words are ever issued
  assign in_range  = (haddr[31:8] == 24'h000000) && (hsize == hsize);
  assign addr_ok   = hsel && hready && htrans[1];
  assign ra.rd_idx = haddr[7:2];
  assign ra.rd_ok  = addr_ok && !hwrite && in_range;
  assign ra.wr_en  = wr_pend_q;
  assign ra.wr_idx = wr_idx_q;
  assign ra.wdata  = hwdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 6'h00;
    end else begin
      wr_pend_q <= addr_ok && hwrite && in_range;
      wr_idx_q  <= haddr[7:2];
    end
  end

  // data outputs from flops; reads in the cycle after a write see old data
  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (ra.rd_ok) begin
      hrdata <= ra.rdata;
    end else if (addr_ok) begin
      hrdata <= 32'h00000000;
    end
  end
endmodule : ahb_reg_port
`default_nettype wire

// >>> core/file_regs.sv
// Purpose: file register array, two read ports and one write port
// Assumes: write and reads on one clock
// Notes:   all entries clear at reset so reads are never unknown
`timescale 1ns/1ns
`default_nettype none
module file_regs #(
  parameter int unsigned DEPTH = 128,
  parameter int unsigned W     = 8,
  parameter int unsigned AW    = 7
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [AW-1:0] raddr_a,
  output logic      [W-1:0]  rdata_a,
  input  wire logic [AW-1:0] raddr_b,
  output logic      [W-1:0]  rdata_b
);
  logic [W-1:0] mem_q [DEPTH];

  assign rdata_a = mem_q[raddr_a];
  assign rdata_b = mem_q[raddr_b];

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (we) begin
      mem_q[waddr] <= wdata;
    end
  end
endmodule : file_regs
`default_nettype wire

// >>> core/exec_core.sv
// Purpose: executes a subset of 8-bit core instructions issued by software
// Assumes: one instruction cycle per clk; fetch and decode sit upstream
// Notes:   an instruction is issued by writing the instruction register
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - watchdog clear zeroes counter and prescaler, sets timeout and power-down
// - call via accumulator pushes pc plus one onto the stack top
// - then pc low byte takes accumulator, pc high takes latch bits 6:0
// - call via accumulator takes two cycles and keeps all flags
// - outside the two clears, destination bit 0 writes accumulator, 1 writes the file register
// - complement inverts file register into destination and updates zero
// - file clear writes 00h to the file register and sets zero
// - decrement subtracts one into destination and updates zero
// - accumulator clear loads 00h and sets zero
// - decrement-and-skip subtracts one into destination, flags untouched
// - zero result discards next instruction as a nop, two cycles
module exec_core #(
  parameter int unsigned FILE_DEPTH = 128,
  parameter int unsigned PRE_W      = exec_pkg::PRESC_W
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata
);
  reg_access_if ra ();

  exec_pkg::state_e                    state_q;
  exec_pkg::op_e                       op_q;
  logic [exec_pkg::FADDR_W-1:0]        faddr_q, fptr_q;
  logic [exec_pkg::DATA_W-1:0]         accum_q, wdog_q;
  logic [exec_pkg::PC_W-1:0]           pc_q, stack_q;
  logic [exec_pkg::LATCH_W-1:0]        latch_q;
  logic                                dest_q, zero_q, to_q, pd_q, wdt_en_q;
  logic [PRE_W-1:0]                    presc_q;
  logic [exec_pkg::CNT_W-1:0]          count_q;

  logic                                wr_instr, wr_stat, wr_accum, wr_pc;
  logic                                wr_latch, wr_ctrl, wr_fptr, wr_fdata;
  logic                                in_exec, res_valid, res_zero, skip;
  logic [exec_pkg::DATA_W-1:0]         operand, bus_fdata, result, fw_data;
  logic                                to_file, to_accum, z_update, z_force;
  logic                                wdog_clear, presc_wrap, wdog_expire;
  logic                                fw_en;
  logic [exec_pkg::FADDR_W-1:0]        fw_addr;
  logic [exec_pkg::PC_W-1:0]           pc_next;

  ////////////////////////////////////////////////////////////////////////////
  // bus front end and file registers
  ahb_reg_port u_port (
    .clk       (clk),
    .rst       (rst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .ra        (ra.port)
  );

  file_regs #(
    .DEPTH (FILE_DEPTH),
    .W     (exec_pkg::DATA_W),
    .AW    (exec_pkg::FADDR_W)
  ) u_files (
    .clk     (clk),
    .rst     (rst),
    .we      (fw_en),
    .waddr   (fw_addr),
    .wdata   (fw_data),
    .raddr_a (faddr_q),
    .rdata_a (operand),
    .raddr_b (fptr_q),
    .rdata_b (bus_fdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // write decode
  always_comb begin
    wr_instr = 1'b0;
    wr_stat  = 1'b0;
    wr_accum = 1'b0;
    wr_pc    = 1'b0;
    wr_latch = 1'b0;
    wr_ctrl  = 1'b0;
    wr_fptr  = 1'b0;
    wr_fdata = 1'b0;
    if (ra.wr_en) begin
      case ({ra.wr_idx, 2'b00})
        exec_pkg::OFF_INSTR: wr_instr = (state_q == exec_pkg::ST_IDLE);
        exec_pkg::OFF_STAT:  wr_stat  = 1'b1;
        exec_pkg::OFF_ACCUM: wr_accum = 1'b1;
        exec_pkg::OFF_PC:    wr_pc    = 1'b1;
        exec_pkg::OFF_LATCH: wr_latch = 1'b1;
        exec_pkg::OFF_CTRL:  wr_ctrl  = 1'b1;
        exec_pkg::OFF_FPTR:  wr_fptr  = 1'b1;
        exec_pkg::OFF_FDATA: wr_fdata = 1'b1;
        default:             wr_instr = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction datapath
  assign in_exec = (state_q == exec_pkg::ST_EXEC);
  always_comb begin
    result    = operand;
    res_valid = 1'b0;
    z_update  = 1'b0;
    z_force   = 1'b0;
    skip      = 1'b0;
    case (op_q)
      exec_pkg::OP_COMPLEMENT_FILE_OP: begin
        result    = ~operand;
        res_valid = 1'b1;
        z_update  = 1'b1;
      end
      exec_pkg::OP_CLEAR_FILE_OP: begin
        result    = exec_pkg::FILE_CLR;
        res_valid = 1'b1;
        z_force   = 1'b1;
      end
      exec_pkg::OP_DECREMENT_FILE_OP: begin
        result    = operand - 8'h01;
        res_valid = 1'b1;
        z_update  = 1'b1;
      end
      exec_pkg::OP_CLEAR_ACCUM_OP: begin
        result    = exec_pkg::ACCUM_RST;
        res_valid = 1'b1;
        z_force   = 1'b1;
      end
      exec_pkg::OP_DECSZ: begin
        result    = operand - 8'h01;
        res_valid = 1'b1;
        skip      = (result == 8'h00);
      end
      default: res_valid = 1'b0;
    endcase
  end

  assign res_zero = (result == 8'h00);
  // clear-file always targets the file, clear-accum always the accumulator
  assign to_file  = in_exec && res_valid && (op_q != exec_pkg::OP_CLEAR_ACCUM_OP)
                    && (dest_q || op_q == exec_pkg::OP_CLEAR_FILE_OP);
  assign to_accum = in_exec && res_valid && !to_file;

  // the executing instruction beats a bus write to the same array
  assign fw_en   = to_file || wr_fdata;
  assign fw_addr = to_file ? faddr_q : fptr_q;
  assign fw_data = to_file ? result : ra.wdata[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: second cycle is an idle slot after the call's push (done in the exec cycle), or the skip nop
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= exec_pkg::ST_IDLE;
    end else begin
      case (state_q)
        exec_pkg::ST_IDLE: begin
          if (wr_instr) begin
            state_q <= exec_pkg::ST_EXEC;
          end
        end
        exec_pkg::ST_EXEC: begin
          if (op_q == exec_pkg::OP_CALL || skip) begin
            state_q <= exec_pkg::ST_SECOND;
          end else begin
            state_q <= exec_pkg::ST_IDLE;
          end
        end
        exec_pkg::ST_SECOND: state_q <= exec_pkg::ST_IDLE;
        default:             state_q <= exec_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      op_q    <= exec_pkg::OP_NOP;
      faddr_q <= '0;
      dest_q  <= 1'b0;
    end else if (wr_instr) begin
      op_q    <= exec_pkg::op_e'(ra.wdata[exec_pkg::INSTR_OP_LSB +: 3]);
      faddr_q <= ra.wdata[exec_pkg::INSTR_F_LSB +: exec_pkg::FADDR_W];
      dest_q  <= ra.wdata[exec_pkg::INSTR_D_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program counter and return stack
  always_comb begin
    pc_next = pc_q + 15'h0001;
    if (op_q == exec_pkg::OP_CALL) begin
      pc_next = {latch_q, accum_q};
    end else if (skip) begin
      // skipped word is passed over, its slot runs as a nop
      pc_next = pc_q + 15'h0002;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pc_q <= exec_pkg::PC_RST;
    end else if (in_exec) begin
      pc_q <= pc_next;
    end else if (wr_pc) begin
      pc_q <= ra.wdata[exec_pkg::PC_W-1:0];
    end
  end

  // only the top entry is kept; deeper stacking lives elsewhere
  always_ff @(posedge clk) begin
    if (rst) begin
      stack_q <= exec_pkg::PC_RST;
    end else if (in_exec && op_q == exec_pkg::OP_CALL) begin
      stack_q <= pc_q + 15'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      latch_q <= '0;
    end else if (wr_latch) begin
      latch_q <= ra.wdata[exec_pkg::LATCH_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulator and zero flag
  always_ff @(posedge clk) begin
    if (rst) begin
      accum_q <= exec_pkg::ACCUM_RST;
    end else if (to_accum) begin
      accum_q <= result;
    end else if (wr_accum) begin
      accum_q <= ra.wdata[7:0];
    end
  end

  // call and decrement-and-skip leave the flag to software only
  always_ff @(posedge clk) begin
    if (rst) begin
      zero_q <= 1'b0;
    end else if (in_exec && z_force) begin
      zero_q <= 1'b1;
    end else if (in_exec && z_update) begin
      zero_q <= res_zero;
    end else if (wr_stat) begin
      zero_q <= ra.wdata[exec_pkg::STAT_Z];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog counter, prescaler and the flags it touches
  assign wdog_clear  = in_exec && (op_q == exec_pkg::OP_WDOG_CLR);
  assign presc_wrap  = wdt_en_q && (presc_q == '1);
  assign wdog_expire = presc_wrap && (wdog_q == 8'hFF);

  always_ff @(posedge clk) begin
    if (rst) begin
      wdt_en_q <= 1'b0;
    end else if (wr_ctrl) begin
      wdt_en_q <= ra.wdata[exec_pkg::CTRL_WDT_EN];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      presc_q <= '0;
      wdog_q  <= exec_pkg::WDOG_CLR;
    end else if (wdog_clear) begin
      presc_q <= '0;
      wdog_q  <= exec_pkg::WDOG_CLR;
    end else if (wdt_en_q) begin
      presc_q <= presc_q + 1'b1;
      if (presc_wrap) begin
        wdog_q <= wdog_q + 8'h01;
      end
    end
  end

  // clear instruction wins over an expiry or a software write
  always_ff @(posedge clk) begin
    if (rst) begin
      to_q <= exec_pkg::FLAG_RST;
      pd_q <= exec_pkg::FLAG_RST;
    end else if (wdog_clear) begin
      to_q <= 1'b1;
      pd_q <= 1'b1;
    end else begin
      if (wdog_expire) begin
        to_q <= 1'b0;
      end else if (wr_stat) begin
        to_q <= ra.wdata[exec_pkg::STAT_TO];
      end
      if (wr_stat) begin
        pd_q <= ra.wdata[exec_pkg::STAT_PD];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // file pointer and retired instruction count
  always_ff @(posedge clk) begin
    if (rst) begin
      fptr_q <= '0;
    end else if (wr_fptr) begin
      fptr_q <= ra.wdata[exec_pkg::FADDR_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= '0;
    end else if (in_exec) begin
      count_q <= count_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux, unmapped words read as zero
  always_comb begin
    ra.rdata = 32'h00000000;
    case ({ra.rd_idx, 2'b00})
      exec_pkg::OFF_INSTR: begin
        ra.rdata[exec_pkg::INSTR_OP_LSB +: 3] = op_q;
        ra.rdata[exec_pkg::INSTR_F_LSB +: exec_pkg::FADDR_W] = faddr_q;
        ra.rdata[exec_pkg::INSTR_D_BIT] = dest_q;
      end
      exec_pkg::OFF_STAT: begin
        ra.rdata[exec_pkg::STAT_BUSY] = (state_q != exec_pkg::ST_IDLE);
        ra.rdata[exec_pkg::STAT_Z]    = zero_q;
        ra.rdata[exec_pkg::STAT_TO]   = to_q;
        ra.rdata[exec_pkg::STAT_PD]   = pd_q;
      end
      exec_pkg::OFF_ACCUM: ra.rdata[7:0] = accum_q;
      exec_pkg::OFF_PC:    ra.rdata[exec_pkg::PC_W-1:0] = pc_q;
      exec_pkg::OFF_LATCH: ra.rdata[exec_pkg::LATCH_W-1:0] = latch_q;
      exec_pkg::OFF_STACK: ra.rdata[exec_pkg::PC_W-1:0] = stack_q;
      exec_pkg::OFF_WDOG: begin
        ra.rdata[7:0] = wdog_q;
        ra.rdata[exec_pkg::WDOG_PRE_LSB +: PRE_W] = presc_q;
      end
      exec_pkg::OFF_CTRL:  ra.rdata[exec_pkg::CTRL_WDT_EN] = wdt_en_q;
      exec_pkg::OFF_FPTR:  ra.rdata[exec_pkg::FADDR_W-1:0] = fptr_q;
      exec_pkg::OFF_FDATA: ra.rdata[7:0] = bus_fdata;
      exec_pkg::OFF_COUNT: ra.rdata[exec_pkg::CNT_W-1:0] = count_q;
      default:             ra.rdata = 32'h00000000;
    endcase
  end
endmodule : exec_core
`default_nettype wire

// >>> sim/exec_core_monitor.sv
// Purpose: bus-side checks on the executor
// Assumes: zero wait state slave, single word transfers
// Notes:   follows the last instruction write to judge results
`timescale 1ns/1ns
`default_nettype none
module exec_core_monitor (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic       take;
  logic       rd_q, wr_q, unm_q, last_q, idle_q, acck_q;
  logic [7:0] a_q, accv_q;
  logic [2:0] op_q;
  assign take = hsel & hready & htrans[1];
  always_ff @(posedge clk) begin
    rd_q  <= !rst & take & !hwrite;
    wr_q  <= !rst & take & hwrite;
    a_q   <= haddr[7:0];
    unm_q <= (haddr[31:8] != 24'h0) | (haddr[7:0] > 8'h2B);
  end
  // any other write voids the result tracking
  always_ff @(posedge clk) begin
    if (rst) begin
      last_q <= 1'b0;
      idle_q <= 1'b0;
      acck_q <= 1'b0;
    end else if (wr_q) begin
      last_q <= (a_q == 8'h00);
      idle_q <= 1'b0;
      acck_q <= (a_q == 8'h08);
      op_q   <= hwdata[2:0];
      accv_q <= hwdata[7:0];
    end else if (rd_q && a_q == 8'h04 && !hrdata[0]) begin
      idle_q <= last_q;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  sequence rd_of(logic [7:0] a);
    rd_q && a_q == a;
  endsequence
  sequence done_of(logic [2:0] op);
    last_q && idle_q && op_q == op;
  endsequence
  AST_READY_ONE: assert property (hreadyout)
    else $error("hreadyout low");
  AST_RESP_OKAY: assert property (!hresp)
    else $error("hresp not okay");
  AST_RDATA_HOLD: assert property (!$past(take) |-> $stable(hrdata))
    else $error("hrdata moved without a transfer");
  AST_UNMAPPED_ZERO: assert property (rd_q && unm_q |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  AST_STAT_HIGH: assert property (rd_of(8'h04) |-> hrdata[31:4] == 28'h0)
    else $error("status upper bits set");
  AST_ACC_HOLD: assert property (rd_of(8'h08) ##0 acck_q
    |-> hrdata == {24'h0, accv_q}) else $error("accumulator lost");
  AST_CLEAR_FILE_OP_ZERO: assert property (
    rd_of(8'h04) ##0 done_of(3'h4) |-> hrdata[1])
    else $error("zero not set by file clear");
  AST_CLEAR_ACCUM_OP_ACCUM: assert property (
    rd_of(8'h08) ##0 done_of(3'h6) |-> hrdata == 32'h0)
    else $error("accumulator not cleared");
  AST_WDOG_FLAGS: assert property (
    rd_of(8'h04) ##0 done_of(3'h1) |-> hrdata[3:2] == 2'b11)
    else $error("timeout or power-down not set");
endmodule : exec_core_monitor
bind exec_core exec_core_monitor exec_core_monitor_inst (.clk(clk),
  .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
`default_nettype wire

// >>> sim/testbench.sv
// Purpose: self-checking bench for the executor
// Assumes: zero wait states, IDLE cycle between transfers
// Notes:   prescaler shortened to keep the watchdog run brief
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  typedef struct packed {
    logic [2:0] op; logic [6:0] f; logic d; logic [7:0] fv, av; logic zin;
    logic [7:0] ea, ef; logic ez; logic [14:0] pcd;
  } row_s;
  logic clk = 0, rst = 1, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, rv;
  logic [1:0]  htrans = 0;
  logic        hready, hresp;
  logic [31:0] hrdata;
  int fail_count = 0, compares = 0, polls = 0;
  row_s rows [9] = '{
    '{3'h3, 7'h05, 1'b1, 8'h5A, 8'h33, 1'b1, 8'h33, 8'hA5, 1'b0, 15'h1},
    '{3'h3, 7'h7F, 1'b0, 8'hFF, 8'h33, 1'b0, 8'h00, 8'hFF, 1'b1, 15'h1},
    '{3'h5, 7'h00, 1'b1, 8'h01, 8'h12, 1'b0, 8'h12, 8'h00, 1'b1, 15'h1},
    '{3'h5, 7'h09, 1'b0, 8'h00, 8'h12, 1'b1, 8'hFF, 8'h00, 1'b0, 15'h1},
    '{3'h4, 7'h07, 1'b0, 8'h3C, 8'h44, 1'b0, 8'h44, 8'h00, 1'b1, 15'h1},
    '{3'h6, 7'h07, 1'b1, 8'h3C, 8'h99, 1'b0, 8'h00, 8'h3C, 1'b1, 15'h1},
    '{3'h7, 7'h11, 1'b1, 8'h02, 8'h21, 1'b1, 8'h21, 8'h01, 1'b1, 15'h1},
    '{3'h7, 7'h12, 1'b0, 8'h01, 8'h21, 1'b0, 8'h00, 8'h01, 1'b0, 15'h2},
    '{3'h0, 7'h12, 1'b0, 8'h01, 8'h21, 1'b1, 8'h21, 8'h01, 1'b1, 15'h1}};
  exec_core #(.PRE_W(2)) exec_core_inst (.clk(clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata));
  always #5 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rv = hrdata;
  endtask : xfer
  task automatic run(input logic [2:0] op, input logic [6:0] f,
                     input logic d);
    int n;
    xfer(1, 8'h00, {19'h0, d, 1'b0, f, 1'b0, op});
    // bounded poll so a stuck busy shows up as a mismatch
    n = 0;
    do begin
      xfer(0, 8'h04, 0);
      n++;
    end while (rv[0] !== 1'b0 && n < 20);
    polls = n;
    `CHK(rv[0], 1'b0)
  endtask : run
  task automatic conclude;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  initial begin
    #200000;
    fail_count++;
    conclude();
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    xfer(0, 8'h04, 0); `CHK(rv, 32'hC)
    xfer(0, 8'h0C, 0); `CHK(rv, 32'h0)
    xfer(0, 8'h30, 0); `CHK(rv, 32'h0)
    foreach (rows[i]) begin
      xfer(1, 8'h20, {25'h0, rows[i].f});
      xfer(1, 8'h24, {24'h0, rows[i].fv});
      xfer(1, 8'h08, {24'h0, rows[i].av});
      xfer(1, 8'h04, {28'h0, 2'b11, rows[i].zin, 1'b0});
      xfer(1, 8'h0C, 32'h10);
      run(rows[i].op, rows[i].f, rows[i].d);
      // a taken skip costs one extra cycle, just as it costs one pc step
      `CHK(polls, rows[i].pcd)
      xfer(0, 8'h08, 0); `CHK(rv[7:0], rows[i].ea)
      xfer(0, 8'h24, 0); `CHK(rv[7:0], rows[i].ef)
      xfer(0, 8'h04, 0); `CHK(rv[1], rows[i].ez)
      xfer(0, 8'h0C, 0); `CHK(rv[14:0], 15'h10 + rows[i].pcd)
    end
    // call through accumulator, latch bit 7 must not reach the pc
    xfer(1, 8'h08, 32'h5C);
    xfer(1, 8'h10, 32'hAA);
    xfer(1, 8'h0C, 32'h0123);
    xfer(1, 8'h04, 32'hE);
    run(3'h2, 7'h00, 1'b0);
    `CHK(polls, 2)
    xfer(0, 8'h14, 0); `CHK(rv[14:0], 15'h0124)
    xfer(0, 8'h0C, 0); `CHK(rv[14:0], 15'h2A5C)
    xfer(0, 8'h04, 0); `CHK(rv[3:1], 3'b111)
    // let the watchdog expire, then stop it so the clear is seen cleanly
    xfer(1, 8'h04, 32'hC);
    xfer(1, 8'h1C, 32'h1);
    repeat (1060) @(posedge clk);
    xfer(1, 8'h1C, 32'h0);
    xfer(0, 8'h18, 0); `CHK(rv[7:0] != 8'h00, 1'b1)
    xfer(0, 8'h04, 0); `CHK(rv[3:1], 3'b100)
    run(3'h1, 7'h00, 1'b0);
    xfer(0, 8'h18, 0); `CHK(rv[15:0], 16'h0)
    xfer(0, 8'h04, 0); `CHK(rv[3:1], 3'b110)
    // mid-run reset must bring the registers back to their reset values
    xfer(0, 8'h28, 0); `CHK(rv, 32'hB)
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    xfer(0, 8'h04, 0); `CHK(rv, 32'hC)
    xfer(0, 8'h28, 0); `CHK(rv, 32'h0)
    xfer(1, 8'h08, 32'hA7);
    xfer(0, 8'h08, 0); `CHK(rv, 32'hA7)
    conclude();
  end
endmodule : testbench
`default_nettype wire
